// [hdl/ifgc_defines.vh]
// Contract
// (RL1) Supply present and chip enable high: active mode, power transfer runs.
// (RL2) Supply present, chip enable low: standby, no transfer, gate output low.
// (RL3) Without a pending fault the gate output follows the enable state.
// (RL4) Comparator output is high while its sense input exceeds the reference.
// (RL5) Rising edges use the selectable deglitch; falling edges a fixed one.
// (RL6) A filtered fault rise forces the gate output low at once.
// (RL7) Any fault starts a recovery timer; gate stays low until it expires.
// (RL8) Non-latched: after clear and expiry the gate follows enable again.
// (RL9) A new fault during recovery restarts the timer from zero.
// (RL10) Fault asserts are stretched for the sampler; recoveries are not.
// (RL11) Fault flag pulls low on sampled fault, releases on sampled recovery.
// (RL12) Each transfer cycle samples comparator state and updates the flags.
// (RL13) Latched: gate stays low until enable low and timer expired.
// (RL14) Latched: flag stays low until enable low; released once fault recovered.
// (RL15) Alarm drives the alarm flag low and never touches the gate.
// (RL16) Three channel configurations; either fault channel disables the gate.
// (RL17) Controller clears a latch by enable low, then high after fault ends.
// (RL18) Recovery hold is typically 165 us, at most 270 us.
// (RL19) Fixed falling deglitch is 4.2 to 8 us, typically 5.7 us.
// (RL20) Rising deglitch ns is max(3.55*R_kohm+153, 235), shared by all channels.
// (RL21) Alarm never latches; flag releases after a sampled alarm recovery.
// (RL22) Comparators are synchronous bits; durations are clock-derived counters.
// (RL23) Flags are open drain: pull low when asserted, output enable off otherwise.
`ifndef IFGC_DEFINES_VH
`define IFGC_DEFINES_VH

// Clock rate in MHz.
`define IFGC_CLK_MHZ 250
// Recovery hold, typical, in microseconds.
`define IFGC_REC_US 165
`define IFGC_REC_CYC (`IFGC_REC_US * `IFGC_CLK_MHZ)
// Falling deglitch, typical, in nanoseconds.
`define IFGC_FALL_NS 5700
`define IFGC_FALL_CYC ((`IFGC_FALL_NS * `IFGC_CLK_MHZ) / 1000)
// Rising deglitch constants; the slope is scaled by 100 to keep integer math.
`define IFGC_RISE_K100 355
`define IFGC_RISE_OFS_NS 153
`define IFGC_RISE_MIN_NS 235
// Back-channel sample period in cycles (one power transfer cycle).
`define IFGC_SAMPLE_CYC 1000
// Stretch of fault/alarm asserts: longer than one sample period.
`define IFGC_STRETCH_CYC (`IFGC_SAMPLE_CYC + 2)
// Channel configurations.
`define IFGC_CFG_FLT_ALM 2'h0
`define IFGC_CFG_FLT_FLT 2'h1
`define IFGC_CFG_ALM_ALM 2'h2
// Counter width for all timers.
`define IFGC_CNT_W 20
// AXI4-Lite register offsets.
`define IFGC_REG_CTRL 4'h0
`define IFGC_REG_RESPONSE_SELECT 4'h4
`define IFGC_REG_STAT 4'h8
// Control field positions and reset values.
`define IFGC_CTRL_CE 0
`define IFGC_CTRL_EN 1
`define IFGC_CTRL_RST 32'h00000000
`define IFGC_RESPONSE_SELECT_RST 32'h00000064

`endif

// [hdl/ifgc_deglitch.v]
`timescale 1ns/10ps
`default_nettype none
`include "ifgc_defines.vh"

module ifgc_deglitch (
    // Clock and reset.
    input wire ref_clk,
    input wire rst_n,
    // Rising qualification length in cycles.
    input wire [`IFGC_CNT_W-1:0] rise_cyc,
    // Raw comparator and filtered output.
    input wire cmp_in,
    output reg filt_ff
);

    reg [`IFGC_CNT_W-1:0] cnt_ff;
    reg [`IFGC_CNT_W-1:0] nxt_cnt;
    reg nxt_filt;

    // An input that differs from the output must persist for the whole window.
    always @* begin
        nxt_filt = filt_ff;
        nxt_cnt = {`IFGC_CNT_W{1'b0}};
        if (cmp_in != filt_ff) begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cmp_in && cnt_ff + 1'b1 >= rise_cyc) begin
                nxt_filt = 1'b1; // RL5
                nxt_cnt = {`IFGC_CNT_W{1'b0}};
            end else if (!cmp_in && cnt_ff + 1'b1 >= `IFGC_FALL_CYC) begin
                nxt_filt = 1'b0; // RL19
                nxt_cnt = {`IFGC_CNT_W{1'b0}};
            end
        end
    end

    // Glitches shorter than the window restart the count.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_ff <= 1'b0;
            cnt_ff <= {`IFGC_CNT_W{1'b0}};
        end else begin
            filt_ff <= nxt_filt;
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // ifgc_deglitch
`default_nettype wire

// [hdl/ifgc_top.v]
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ifgc_defines.vh"

module ifgc_top #(
    parameter [1:0] CFG = `IFGC_CFG_FLT_ALM,
    parameter LATCHED = 0,
    parameter [`IFGC_CNT_W-1:0] REC_CYC = `IFGC_REC_CYC,
    parameter [`IFGC_CNT_W-1:0] SAMPLE_CYC = `IFGC_SAMPLE_CYC
) (
    // Clock and reset.
    input wire ref_clk,
    input wire rst_n,
    // Supply status.
    input wire primary_supply,
    // Comparator results, one per channel.
    input wire [1:0] sense_in,
    // Gate output.
    output reg gate_drive_ff,
    // Open-drain flags: channel 0 and channel 1 indicator outputs; power_ok_flag is a plain output that follows active mode.
    output wire [1:0] fault_indicator_n_o,
    output wire [1:0] fault_indicator_n_oe,
    output wire [1:0] alarm_flag_n_o,
    output wire [1:0] alarm_flag_n_oe,
    output wire power_ok_flag,
    // AXI4-Lite slave.
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ------------------------------------------------------------------
    // Channel roles
    // ------------------------------------------------------------------

    // Decode whether a channel acts as a fault channel for this variant.
    function is_fault;
        input [1:0] cfg;
        input integer ch;
        begin
            is_fault = (cfg == `IFGC_CFG_FLT_FLT) ||
                       (cfg == `IFGC_CFG_FLT_ALM && ch == 0); // RL16
        end
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------

    reg [31:0] ctrl_ff;
    reg [31:0] response_select_ff;
    reg [`IFGC_CNT_W-1:0] rise_cyc_ff;
    reg [3:0] awaddr_ff;
    reg aw_have_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg w_have_ff;
    wire chip_en;
    wire sw_enable;
    wire active;
    wire [31:0] stat_word;
    wire [31:0] rise_ns;
    integer b;

    // Active mode needs both the supply and chip enable.
    assign chip_en = ctrl_ff[`IFGC_CTRL_CE];
    assign sw_enable = ctrl_ff[`IFGC_CTRL_EN];
    assign active = primary_supply & chip_en; // RL1
    assign power_ok_flag = active;

    // Rising window from the response resistance in kilo-ohms.
    assign rise_ns = ((response_select_ff * `IFGC_RISE_K100) / 100 + `IFGC_RISE_OFS_NS >
                      `IFGC_RISE_MIN_NS) ?
                     (response_select_ff * `IFGC_RISE_K100) / 100 + `IFGC_RISE_OFS_NS :
                     `IFGC_RISE_MIN_NS; // RL20

    // Ready drops while a word is held or an answer waits, so nothing is overwritten.
    assign s_axi_awready = !aw_have_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_have_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data are captured separately; the write lands when both are held.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `IFGC_CTRL_RST;
            response_select_ff <= `IFGC_RESPONSE_SELECT_RST;
            rise_cyc_ff <= {`IFGC_CNT_W{1'b1}};
            awaddr_ff <= 4'h0;
            aw_have_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            w_have_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            rise_cyc_ff <= rise_ns[`IFGC_CNT_W+1:2]; // Divide by 4 ns per cycle.
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
                aw_have_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_have_ff <= 1'b1;
            end
            if (aw_have_ff && w_have_ff) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                for (b = 0; b < 4; b = b + 1) begin
                    if (wstrb_ff[b] && awaddr_ff == `IFGC_REG_CTRL)
                        ctrl_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
                    if (wstrb_ff[b] && awaddr_ff == `IFGC_REG_RESPONSE_SELECT)
                        response_select_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
                end
                if (awaddr_ff != `IFGC_REG_CTRL && awaddr_ff != `IFGC_REG_RESPONSE_SELECT)
                    s_axi_bresp <= 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Reads answer one cycle after the address is taken; unmapped gives SLVERR.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `IFGC_REG_CTRL: s_axi_rdata <= ctrl_ff;
                `IFGC_REG_RESPONSE_SELECT: s_axi_rdata <= response_select_ff;
                `IFGC_REG_STAT: s_axi_rdata <= stat_word;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------------

    wire [1:0] filt;
    wire [1:0] fault_rise;
    wire [1:0] stretched;
    // Stretch length as a sized word; it outlasts the default sample period.
    localparam [31:0] STRETCH_W = `IFGC_STRETCH_CYC;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            // Per-channel state keeps each register driven from one process.
            reg filt_d_ff;
            reg [`IFGC_CNT_W-1:0] stretch_ff;

            // Each comparator bit is already high while the input exceeds the reference.
            ifgc_deglitch u_dg (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .rise_cyc(rise_cyc_ff),
                .cmp_in(sense_in[g] & active), // RL4 RL22
                .filt_ff(filt[g])
            );

            // A fault rise is the first cycle of a filtered high on a fault channel.
            assign fault_rise[g] = filt[g] & ~filt_d_ff & is_fault(CFG, g);

            // Asserts are held beyond a sample period so the sampler never misses one.
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    filt_d_ff <= 1'b0;
                    stretch_ff <= {`IFGC_CNT_W{1'b0}};
                end else begin
                    filt_d_ff <= filt[g];
                    if (filt[g] & ~filt_d_ff)
                        stretch_ff <= STRETCH_W[`IFGC_CNT_W-1:0]; // RL10
                    else if (stretch_ff != 0)
                        stretch_ff <= stretch_ff - 1'b1;
                end
            end
            assign stretched[g] = filt[g] | (stretch_ff != 0);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Recovery timer and latch
    // ------------------------------------------------------------------

    reg [`IFGC_CNT_W-1:0] rec_ff;
    reg latch_ff;
    wire any_fault;
    wire any_rise;
    wire rec_run;

    // Alarm channels are left out here, so an alarm never touches the gate.
    assign any_fault = (filt[0] & is_fault(CFG, 0)) | (filt[1] & is_fault(CFG, 1));
    assign any_rise = |fault_rise;
    assign rec_run = (rec_ff != 0);

    // The timer holds full while the fault stands and runs down once it clears.
    // Reloading on every fault cycle means a fault that returns during recovery
    // restarts the hold from its full length.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_ff <= {`IFGC_CNT_W{1'b0}};
            latch_ff <= 1'b0;
        end else begin
            if (any_rise || any_fault)
                rec_ff <= REC_CYC; // RL7 RL9 RL18
            else if (rec_run)
                rec_ff <= rec_ff - 1'b1;
            // A fault rise in a cycle with enable low wins over the clear.
            if (LATCHED != 0 && any_rise)
                latch_ff <= 1'b1; // RL13
            else if (!sw_enable)
                latch_ff <= 1'b0; // RL17
        end
    end

    // Gate follows enable only with no fault, no recovery hold and no latch.
    // A cleared latch still waits for the timer, so a quick enable toggle
    // cannot turn the switch back on early.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            gate_drive_ff <= 1'b0;
        else if (!active)
            gate_drive_ff <= 1'b0; // RL2
        else if (any_rise || any_fault || rec_run || latch_ff)
            gate_drive_ff <= 1'b0; // RL6 RL8 RL13
        else
            gate_drive_ff <= sw_enable; // RL3
    end

    // ------------------------------------------------------------------
    // Back-channel sampling and flags
    // ------------------------------------------------------------------

    reg [`IFGC_CNT_W-1:0] smp_cnt_ff;
    reg [1:0] flag_ff;
    reg [1:0] flt_held_ff;
    wire smp_tick;
    integer c;

    assign smp_tick = (smp_cnt_ff == SAMPLE_CYC - 1'b1);

    // One sample per power transfer cycle; stopped in standby.
    // Flags change only at a tick, so a recovery shorter than one sample period
    // may go unseen, while stretched asserts never do.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_ff <= {`IFGC_CNT_W{1'b0}};
            flag_ff <= 2'h0;
            flt_held_ff <= 2'h0;
        end else begin
            smp_cnt_ff <= (smp_tick || !active) ? {`IFGC_CNT_W{1'b0}} :
                          smp_cnt_ff + 1'b1;
            for (c = 0; c < 2; c = c + 1) begin
                if (LATCHED != 0 && fault_rise[c])
                    flt_held_ff[c] <= 1'b1; // RL14
                else if (!sw_enable && !filt[c])
                    flt_held_ff[c] <= 1'b0; // RL14
                if (smp_tick)
                    flag_ff[c] <= stretched[c] | flt_held_ff[c]; // RL11 RL12 RL15 RL21
            end
        end
    end

    // Status for software: latch, recovery running, flags and filtered bits.
    assign stat_word = {26'h0, latch_ff, rec_run, flag_ff, filt};

    // Open-drain drive: output is always zero, enable pulls the wire low.
    assign fault_indicator_n_o = 2'h0;
    assign alarm_flag_n_o = 2'h0;
    assign fault_indicator_n_oe[0] = flag_ff[0] & is_fault(CFG, 0); // RL23
    assign fault_indicator_n_oe[1] = flag_ff[1] & is_fault(CFG, 1); // RL23
    assign alarm_flag_n_oe[0] = flag_ff[0] & ~is_fault(CFG, 0); // RL15 RL23
    assign alarm_flag_n_oe[1] = flag_ff[1] & ~is_fault(CFG, 1); // RL23

endmodule // ifgc_top
`default_nettype wire

// [tb/ifgc_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none

module ifgc_ctrl_model (
    // Open-drain pins of the block.
    input wire logic [1:0] flt_o,
    input wire logic [1:0] flt_oe,
    input wire logic [1:0] alm_o,
    input wire logic [1:0] alm_oe,
    // Levels seen by the controller.
    output logic [1:0] flt_line_n,
    output logic [1:0] alm_line_n
);
    // ------------------------------------------------------------
    // Pull-up resolution
    // ------------------------------------------------------------
    // A released pin floats to the pull-up, so a stale low can never be read.
    assign flt_line_n = (flt_oe & flt_o) | ~flt_oe;
    assign alm_line_n = (alm_oe & alm_o) | ~alm_oe;
endmodule // ifgc_ctrl_model

`default_nettype wire

// [tb/ifgc_checker_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

module ifgc_checker #(
    parameter int LATCHED = 0,
    parameter int REC_CYC = 200,
    parameter int SAMPLE_CYC = 20
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Block pins.
    input wire logic [1:0] sense_in,
    input wire logic gate_drive_ff,
    input wire logic power_ok_flag,
    input wire logic [1:0] fault_indicator_n_o,
    input wire logic [1:0] fault_indicator_n_oe,
    input wire logic [1:0] alarm_flag_n_o,
    input wire logic [1:0] alarm_flag_n_oe,
    // Bus handshakes.
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ------------------------------------------------------------
    // Run-length counters
    // ------------------------------------------------------------
    // The default response setting qualifies a rise in 127 cycles.
    localparam int RISE = 135;
    localparam int FLAG = RISE + SAMPLE_CYC + 8;
    // Low time counts from the last qualified cycle, so it never overshoots.
    localparam int HOLD = 1400 + REC_CYC;
    localparam int FREE = 2600;
    localparam int TOP = 4000;
    logic [12:0] hi0_ff;
    logic [12:0] hi1_ff;
    logic [12:0] lo_ff;

    // Standby masks the comparators, so every count starts over there.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi0_ff <= 13'h0;
            hi1_ff <= 13'h0;
            lo_ff <= 13'(TOP);
        end else if (!power_ok_flag) begin
            hi0_ff <= 13'h0;
            hi1_ff <= 13'h0;
            lo_ff <= 13'(TOP);
        end else begin
            hi0_ff <= sense_in[0] ? hi0_ff + 13'(hi0_ff < 13'(TOP)) : 13'h0;
            hi1_ff <= sense_in[1] ? hi1_ff + 13'(hi1_ff < 13'(TOP)) : 13'h0;
            lo_ff <= (hi0_ff >= 13'(RISE)) ? 13'h0 : lo_ff + 13'(lo_ff < 13'(TOP));
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_standby_gate_low: assert property (!power_ok_flag [*3] |-> !gate_drive_ff)
        else $error("gate high without power");
    a_fault_gate_low: assert property (hi0_ff >= 13'(RISE) |-> !gate_drive_ff)
        else $error("gate high during qualified fault");
    a_recovery_hold: assert property (lo_ff < 13'(HOLD) |-> !gate_drive_ff)
        else $error("gate rose before recovery ended");
    a_fault_flag_set: assert property (hi0_ff >= 13'(FLAG) |-> fault_indicator_n_oe[0])
        else $error("fault flag not pulled low");
    a_alarm_flag_set: assert property (hi1_ff >= 13'(FLAG) |-> alarm_flag_n_oe[1])
        else $error("alarm flag not pulled low");
    a_fault_flag_free: assert property (LATCHED == 0 && lo_ff == 13'(FREE) |->
        !fault_indicator_n_oe[0]) else $error("fault flag not released");
    a_open_drain_low: assert property (
        ((fault_indicator_n_oe & fault_indicator_n_o) | (alarm_flag_n_oe & alarm_flag_n_o))
        == 2'h0) else $error("open drain drives high");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule // ifgc_checker

bind ifgc_top ifgc_checker #(.LATCHED(LATCHED), .REC_CYC(REC_CYC), .SAMPLE_CYC(SAMPLE_CYC)) chk_u (
    .ref_clk, .rst_n, .sense_in, .gate_drive_ff, .power_ok_flag, .fault_indicator_n_o,
    .fault_indicator_n_oe, .alarm_flag_n_o, .alarm_flag_n_oe, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid
);

`default_nettype wire

// [tb/test_isolated_fault_gate_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ifgc_defines.vh"
`define CHK(g, e) begin @(negedge ref_clk); n_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module test_isolated_fault_gate_control;
    // ------------------------------------------------------------
    // Bench signals and instances
    // ------------------------------------------------------------
    localparam int REC = 200;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic primary_supply = 1'b1;
    logic [1:0] sense_in = 2'h0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire gate, pok, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] fo, foe, ao, aoe, fln, aln, s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire lgate;
    wire [1:0] lfoe;
    int fail_count = 0;
    int n_checks = 0;
    int en;
    logic [31:0] rd_v;
    logic [1:0] rs_v;

    always #2 ref_clk = ~ref_clk;

    ifgc_top #(.REC_CYC(20'(REC)), .SAMPLE_CYC(20'h14)) dut_u (
        .ref_clk, .rst_n, .primary_supply, .sense_in, .gate_drive_ff(gate),
        .fault_indicator_n_o(fo), .fault_indicator_n_oe(foe), .alarm_flag_n_o(ao),
        .alarm_flag_n_oe(aoe), .power_ok_flag(pok), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    ifgc_ctrl_model pm_u (.flt_o(fo), .flt_oe(foe), .alm_o(ao), .alm_oe(aoe),
        .flt_line_n(fln), .alm_line_n(aln));
    // A latched twin shares every input, so one stimulus exercises both variants.
    ifgc_top #(.LATCHED(1), .REC_CYC(20'(REC)), .SAMPLE_CYC(20'h14)) dut_l (
        .ref_clk, .rst_n, .primary_supply, .sense_in, .gate_drive_ff(lgate),
        .fault_indicator_n_o(), .fault_indicator_n_oe(lfoe), .alarm_flag_n_o(),
        .alarm_flag_n_oe(), .power_ok_flag(), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready
    );

    // Cycles a rise must last for a response setting in kilo-ohms.
    function automatic int rise_cyc(input int r);
        int ns;
        ns = (355 * r + 15300) / 100;
        if (ns < 235) ns = 235;
        return ns / 4;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Bus tasks sample at the falling edge; the transfer lands on the next rise.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int t;
        tb = 1'b0;
        t = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb && t < 100) begin
            @(negedge ref_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rs_v = s_axi_bresp;
            @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            t++;
        end
        s_axi_bready <= 1'b0;
        if (!tb) fail_count++;
    endtask

    task automatic rdt(input logic [3:0] a);
        logic tk, tv;
        int t;
        tv = 1'b0;
        t = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tv && t < 100) begin
            @(negedge ref_clk);
            tk = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            rd_v = s_axi_rdata;
            rs_v = s_axi_rresp;
            @(posedge ref_clk);
            if (tk) s_axi_arvalid <= 1'b0;
            t++;
        end
        s_axi_rready <= 1'b0;
        if (!tv) fail_count++;
    endtask

    task automatic pulse(input int ch, input int n);
        @(posedge ref_clk);
        sense_in[ch] <= 1'b1;
        cyc(n);
        sense_in[ch] <= 1'b0;
    endtask

    // Fault held past qualification; pre is the gate level just before it.
    task automatic trip(input int r, input int n, input logic pre);
        @(posedge ref_clk);
        sense_in[0] <= 1'b1;
        cyc(rise_cyc(r) - 6);
        `CHK(gate, pre)
        cyc(n);
        `CHK(gate, 1'b0)
        `CHK(fln[0], 1'b0)
        @(posedge ref_clk);
        sense_in[0] <= 1'b0;
    endtask

    // The gate stays low for the fall filter plus the recovery time, then follows.
    task automatic recover;
        cyc(`IFGC_FALL_CYC + REC - 30);
        `CHK(gate, 1'b0)
        cyc(60);
        `CHK(gate, 1'b1)
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    initial begin
        rd_v = $urandom(67614);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdt(4'h0);
        `CHK(rd_v, 32'h00000000)
        rdt(4'h4);
        `CHK(rd_v, 32'h00000064)
        rdt(4'hC);
        `CHK(rs_v, 2'h2)
        `CHK(gate, 1'b0)
        wr(4'h0, 32'h1);
        `CHK(pok, 1'b1)
        repeat (6) begin
            en = $urandom_range(1, 0);
            wr(4'h0, {30'h0, en[0], 1'b1});
            cyc(4);
            `CHK(gate, en[0])
        end
        wr(4'h0, 32'h3);
        repeat (5) begin
            pulse(0, $urandom_range(rise_cyc(100) - 10, 1));
            `CHK(gate, 1'b1)
        end
        trip(100, 60, 1'b1);
        recover();
        `CHK(fln[0], 1'b1)
        `CHK(lgate, 1'b0)
        `CHK(lfoe[0], 1'b1)
        wr(4'h0, 32'h1);
        cyc(30);
        `CHK(lfoe[0], 1'b0)
        wr(4'h0, 32'h3);
        cyc(4);
        `CHK(lgate, 1'b1)
        `CHK(gate, 1'b1)
        trip(100, 60, 1'b1);
        // The next fault qualifies while the recovery timer still runs.
        cyc(`IFGC_FALL_CYC);
        trip(100, 60, 1'b0);
        recover();
        pulse(1, 300);
        `CHK(aln[1], 1'b0)
        `CHK(gate, 1'b1)
        rdt(4'h8);
        `CHK(rd_v, 32'h0000000A)
        cyc(`IFGC_FALL_CYC + 60);
        `CHK(aln[1], 1'b1)
        wr(4'h4, 32'hA);
        pulse(0, rise_cyc(10) - 8);
        `CHK(gate, 1'b1)
        trip(10, 40, 1'b1);
        recover();
        wr(4'hC, 32'h5A);
        `CHK(rs_v, 2'h2)
        wr(4'h0, 32'h2);
        cyc(4);
        `CHK(gate, 1'b0)
        `CHK(pok, 1'b0)
        wr(4'h0, 32'h3);
        primary_supply <= 1'b0;
        cyc(4);
        `CHK(gate, 1'b0)
        `CHK(pok, 1'b0)
        summarize();
    end
endmodule // test_isolated_fault_gate_control

`default_nettype wire
